// ===== sqa_device.sv
// sdram quad bank access device logic with apb mode and status registers
//
// Contract
// - all pins are sampled only on the rising edge of clk_sys.
// - burst length one, two, four, eight or full page, set in mode.
// - activate uses two bank bits and twelve row lines.
// - read or write address gives the starting column in the open row.
// - each bank 4096 rows; column width follows the data organisation.
// - device generates following burst columns itself in programmed order.
// - burst terminate stops any burst, full page ends only that way; the code also ends a full page burst by itself after one pass of the row.
// - auto precharge closes the row self-timed when the burst ends.
// - a new column command is accepted every cycle.
// - one bank may precharge while another is accessed.
// - self refresh offered, refused on automotive grade.
// - concurrent auto precharge and auto refresh are provided.
// - read data arrives two or three clocks after read.
// - power-down mode is provided.
`timescale 1ns/1ns
`include "sqa_map.svh"
module sqa_device
    import sqa_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int ROW_W = 12,
    parameter int COL_W = 8
) (
    input wire logic clk_sys, // system clock
    input wire logic reset, // async reset, active high
    input wire sqa_pins_type pins, // command and address pins
    input wire logic [DATA_W-1:0] dqIn, // data pins, input side
    output logic [DATA_W-1:0] dqOut_ff, // data pins, output side
    output logic dqOe_ff, // data pins driven
    input wire sqa_apb_req_type apbReq, // apb request
    output logic [31:0] prdata_ff, // apb read data
    output logic pready_ff, // apb ready
    output logic pslverr_ff // apb error
);
    localparam int ADDR_W = 2 + ROW_W + COL_W;
    localparam logic [2:0] TRP_CYC = 3'(`SQA_TRP_CYC);
    localparam logic [10:0] SELF_CYC = 11'(`SQA_SELF_REF_CYC);

    sqa_state_type q_ff;
    sqa_state_type nxt_q;
    logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];

    logic [3:0] cmd;
    logic cmdOn;
    logic [1:0] cmdBank;
    logic stepOn;
    logic stepWr;
    logic stepAp;
    logic [1:0] stepBank;
    logic [9:0] stepStart;
    logic [10:0] stepIdx;
    logic [10:0] stepLen;
    logic [9:0] stepCol;
    logic ilv;
    logic cl2;
    logic memWe;
    logic [ADDR_W-1:0] memIdx;
    logic [DATA_W-1:0] rdWord;
    logic [1:0] evtSet;
    logic [1:0] evtClr;
    logic apbAccess;
    logic apbMapped;
    logic [31:0] apbRead;

    function automatic logic [10:0] sqaBurstLen(input logic [2:0] code);
        case (code)
            3'h0: return 11'h001;
            3'h1: return 11'h002;
            3'h2: return 11'h004;
            3'h3: return 11'h008;
            3'h7: return 11'(1 << COL_W);
            default: return 11'h001;
        endcase
    endfunction : sqaBurstLen

    function automatic logic [9:0] sqaColAt(input logic [9:0] start, input logic [10:0] idx,
                                            input logic [10:0] len, input logic inter);
        logic [9:0] mask;
        logic [9:0] step;
        mask = 10'(len - 11'h001);
        step = inter ? (start ^ idx[9:0]) : (start + idx[9:0]);
        return (start & ~mask) | (step & mask);
    endfunction : sqaColAt

    function automatic logic [ADDR_W-1:0] sqaIdx(input logic [1:0] bank, input logic [11:0] row,
                                                 input logic [9:0] col);
        return {bank, row[ROW_W-1:0], col[COL_W-1:0]};
    endfunction : sqaIdx

    always_comb begin
        nxt_q = q_ff;
        cmd = {pins.csN, pins.rasN, pins.casN, pins.weN};
        cmdBank = {pins.bankSelectMsb, pins.bankSelectLsb};
        cmdOn = pins.cke && (q_ff.pwr == PWR_RUN);
        cl2 = (q_ff.mode[`SQA_MODE_CL_LSB +: 2] == 2'h2);
        evtSet = 2'h0;
        evtClr = 2'h0;
        for (int b = 0; b < 4; b++) begin
            if (q_ff.preCnt[b] != 3'h0) begin
                nxt_q.preCnt[b] = q_ff.preCnt[b] - 3'h1;
            end
        end
        nxt_q.pipeVal[1] = q_ff.pipeVal[0];
        nxt_q.pipeDat[1] = q_ff.pipeDat[0];
        nxt_q.pipeVal[0] = 1'b0;
        nxt_q.dqOut = cl2 ? q_ff.pipeDat[0] : q_ff.pipeDat[1];
        nxt_q.dqOe = cl2 ? q_ff.pipeVal[0] : q_ff.pipeVal[1];
        stepOn = q_ff.burstOn;
        stepWr = q_ff.burstWr;
        stepAp = q_ff.burstAp;
        stepBank = q_ff.burstBank;
        stepStart = q_ff.burstStart;
        stepIdx = q_ff.burstIdx;
        stepLen = q_ff.burstLen;
        case (q_ff.pwr)
            PWR_RUN: begin
                if (!pins.cke) begin
                    if (!pins.csN && cmd == CMD_REF && !q_ff.mode[`SQA_MODE_AUTO_BIT]) begin
                        nxt_q.pwr = PWR_SELF;
                        nxt_q.selfCnt = 11'h000;
                    end else begin
                        nxt_q.pwr = PWR_DOWN;
                        if (!pins.csN && cmd == CMD_REF) begin
                            evtSet[`SQA_EVT_SELF_BIT] = 1'b1;
                        end
                    end
                end
            end
            PWR_DOWN: begin
                if (pins.cke) begin
                    nxt_q.pwr = PWR_RUN;
                end
            end
            PWR_SELF: begin
                if (q_ff.selfCnt == SELF_CYC - 11'h001) begin
                    nxt_q.selfCnt = 11'h000;
                    nxt_q.refRow = q_ff.refRow + 12'h001;
                end else begin
                    nxt_q.selfCnt = q_ff.selfCnt + 11'h001;
                end
                if (pins.cke) begin
                    nxt_q.pwr = PWR_RUN;
                end
            end
            default: nxt_q.pwr = PWR_RUN;
        endcase
        if (cmdOn && !pins.csN) begin
            case (cmd)
                CMD_ACTIVE: begin
                    if (q_ff.bankOpen[cmdBank] || q_ff.preCnt[cmdBank] != 3'h0) begin
                        evtSet[`SQA_EVT_MISUSE_BIT] = 1'b1;
                    end else begin
                        nxt_q.bankOpen[cmdBank] = 1'b1;
                        nxt_q.openRow[cmdBank] = pins.rowColAddressLines;
                    end
                end
                CMD_READ, CMD_WRITE: begin
                    if (!q_ff.bankOpen[cmdBank]) begin
                        evtSet[`SQA_EVT_MISUSE_BIT] = 1'b1;
                    end else begin
                        if (q_ff.burstOn && q_ff.burstAp) begin
                            nxt_q.bankOpen[q_ff.burstBank] = 1'b0;
                            nxt_q.preCnt[q_ff.burstBank] = TRP_CYC;
                        end
                        stepOn = 1'b1;
                        stepWr = (cmd == CMD_WRITE);
                        stepAp = pins.rowColAddressLines[`SQA_AP_BIT];
                        stepBank = cmdBank;
                        stepStart = 10'(pins.rowColAddressLines[COL_W-1:0]);
                        stepIdx = 11'h000;
                        stepLen = sqaBurstLen(q_ff.mode[`SQA_MODE_BL_LSB +: 3]);
                    end
                end
                CMD_BST: begin
                    stepOn = 1'b0;
                end
                CMD_PRE: begin
                    for (int b = 0; b < 4; b++) begin
                        if (pins.rowColAddressLines[`SQA_AP_BIT] || cmdBank == 2'(b)) begin
                            nxt_q.bankOpen[b] = 1'b0;
                            if (q_ff.bankOpen[b]) begin
                                nxt_q.preCnt[b] = TRP_CYC;
                            end
                            if (q_ff.burstOn && q_ff.burstBank == 2'(b)) begin
                                stepOn = 1'b0;
                            end
                        end
                    end
                end
                CMD_REF: begin
                    if (q_ff.bankOpen != 4'h0 || q_ff.burstOn) begin
                        evtSet[`SQA_EVT_MISUSE_BIT] = 1'b1;
                    end else begin
                        nxt_q.refRow = q_ff.refRow + 12'h001;
                    end
                end
                default: begin
                end
            endcase
        end
        ilv = q_ff.mode[`SQA_MODE_ILV_BIT] && (stepLen != 11'(1 << COL_W));
        stepCol = sqaColAt(stepStart, stepIdx, stepLen, ilv);
        memIdx = sqaIdx(stepBank, q_ff.openRow[stepBank], stepCol);
        memWe = stepOn && stepWr && cmdOn;
        nxt_q.burstOn = stepOn;
        nxt_q.burstWr = stepWr;
        nxt_q.burstAp = stepAp;
        nxt_q.burstBank = stepBank;
        nxt_q.burstStart = stepStart;
        nxt_q.burstLen = stepLen;
        nxt_q.burstIdx = stepIdx + 11'h001;
        if (stepOn && !cmdOn) begin
            nxt_q.burstIdx = stepIdx;
        end else if (stepOn) begin
            if (!stepWr) begin
                nxt_q.pipeVal[0] = 1'b1;
                nxt_q.pipeDat[0] = 16'(rdWord);
            end
            if (stepIdx + 11'h001 == stepLen) begin
                nxt_q.burstOn = 1'b0;
                if (stepAp) begin
                    nxt_q.bankOpen[stepBank] = 1'b0;
                    nxt_q.preCnt[stepBank] = TRP_CYC;
                end
            end
        end
        // apb slave, one wait state
        apbAccess = apbReq.psel && apbReq.penable && q_ff.pready;
        apbMapped = 1'b1;
        case (apbReq.paddr)
            `SQA_MODE_OFFSET: apbRead = q_ff.mode;
            `SQA_STATUS_OFFSET: begin
                apbRead = {22'h0, q_ff.pwr, q_ff.burstOn, 6'h0};
                for (int b = 0; b < 4; b++) begin
                    apbRead[b] = q_ff.bankOpen[b];
                    apbRead[b + 12] = (q_ff.preCnt[b] != 3'h0);
                end
            end
            `SQA_REFCNT_OFFSET: apbRead = {20'h0, q_ff.refRow};
            `SQA_EVENT_OFFSET: apbRead = {30'h0, q_ff.events};
            default: begin
                apbRead = 32'h0;
                apbMapped = 1'b0;
            end
        endcase
        nxt_q.pready = apbReq.psel && apbReq.penable && !q_ff.pready;
        nxt_q.prdata = apbRead;
        nxt_q.pslverr = !apbMapped;
        if (apbAccess && apbReq.pwrite) begin
            if (apbReq.paddr == `SQA_MODE_OFFSET) begin
                nxt_q.mode = apbReq.pwdata & `SQA_MODE_WMASK;
            end
            if (apbReq.paddr == `SQA_EVENT_OFFSET) begin
                evtClr = apbReq.pwdata[1:0];
            end
        end
        // set wins over clear
        nxt_q.events = (q_ff.events & ~evtClr) | evtSet;
    end

    assign rdWord = mem[memIdx];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            q_ff <= '{pwr: PWR_RUN, mode: `SQA_MODE_RESET, default: '0};
        end else begin
            q_ff <= nxt_q;
        end
    end

    // storage sized by row and column width
    always_ff @(posedge clk_sys) begin
        if (memWe) begin
            mem[memIdx] <= dqIn;
        end
    end

    assign dqOut_ff = q_ff.dqOut[DATA_W-1:0];
    assign dqOe_ff = q_ff.dqOe;
    assign prdata_ff = q_ff.prdata;
    assign pready_ff = q_ff.pready;
    assign pslverr_ff = q_ff.pslverr;
endmodule : sqa_device

// ===== sqa_map.svh
// register offsets, field positions, reset values and timing counts of the sdram block
`ifndef SQA_MAP_SVH
`define SQA_MAP_SVH
`define SQA_MODE_OFFSET 12'h000
`define SQA_STATUS_OFFSET 12'h004
`define SQA_REFCNT_OFFSET 12'h008
`define SQA_EVENT_OFFSET 12'h00c
`define SQA_MODE_BL_LSB 0
`define SQA_MODE_ILV_BIT 3
`define SQA_MODE_CL_LSB 4
`define SQA_MODE_AUTO_BIT 8
`define SQA_MODE_WMASK 32'h0000_013f
`define SQA_MODE_RESET 32'h0000_0023
`define SQA_EVT_SELF_BIT 0
`define SQA_EVT_MISUSE_BIT 1
`define SQA_AP_BIT 10
`define SQA_CLK_MHZ 100
`define SQA_TRP_NS 20
`define SQA_TRP_CYC ((`SQA_TRP_NS * `SQA_CLK_MHZ + 999) / 1000)
`define SQA_SELF_REF_NS 15600
`define SQA_SELF_REF_CYC ((`SQA_SELF_REF_NS * `SQA_CLK_MHZ) / 1000)
`endif

// ===== sqa_pkg.sv
// types shared by the sdram quad bank access block
package sqa_pkg;
    typedef enum logic [2:0] {
        PWR_RUN = 3'b001,
        PWR_DOWN = 3'b010,
        PWR_SELF = 3'b100
    } sqa_pwr_type;

    typedef enum logic [3:0] {
        CMD_ACTIVE = 4'h3,
        CMD_READ = 4'h5,
        CMD_WRITE = 4'h4,
        CMD_BST = 4'h6,
        CMD_PRE = 4'h2,
        CMD_REF = 4'h1
    } sqa_cmd_type;

    typedef struct packed {
        logic cke;
        logic csN;
        logic rasN;
        logic casN;
        logic weN;
        logic bankSelectMsb;
        logic bankSelectLsb;
        logic [11:0] rowColAddressLines;
    } sqa_pins_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sqa_apb_req_type;

    typedef struct packed {
        logic [3:0] bankOpen;
        logic [3:0][11:0] openRow;
        logic [3:0][2:0] preCnt;
        logic burstOn;
        logic burstWr;
        logic burstAp;
        logic [1:0] burstBank;
        logic [9:0] burstStart;
        logic [10:0] burstIdx;
        logic [10:0] burstLen;
        logic [1:0] pipeVal;
        logic [1:0][15:0] pipeDat;
        logic [15:0] dqOut;
        logic dqOe;
        sqa_pwr_type pwr;
        logic [10:0] selfCnt;
        logic [31:0] mode;
        logic [11:0] refRow;
        logic [1:0] events;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sqa_state_type;
endpackage : sqa_pkg

// ===== sqa_device_checker.sv
// concurrent checks on the sdram device ports
`timescale 1ns/1ns
`include "sqa_map.svh"
module sqa_device_checker
    import sqa_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int ROW_W = 12,
    parameter int COL_W = 8
) (
    input wire logic clk_sys, // system clock
    input wire logic reset, // async reset
    input wire sqa_pins_type pins, // command pins
    input wire logic [DATA_W-1:0] dqIn, // write data
    input wire logic [DATA_W-1:0] dqOut_ff, // read data
    input wire logic dqOe_ff, // read data driven
    input wire sqa_apb_req_type apbReq, // apb request
    input wire logic [31:0] prdata_ff, // apb read data
    input wire logic pready_ff, // apb ready
    input wire logic pslverr_ff // apb error
);
    logic [31:0] mode_ff;
    logic [31:0] nxt_mode;
    logic isRead;
    logic take;
    logic cl2;
    assign isRead = pins.cke && {pins.csN, pins.rasN, pins.casN, pins.weN} == CMD_READ;
    assign take = apbReq.psel && apbReq.penable && pready_ff;
    assign cl2 = mode_ff[5:4] == 2'd2;
    // shadow of the mode register
    assign nxt_mode = (take && apbReq.pwrite && apbReq.paddr == 12'h000) ?
        (apbReq.pwdata & `SQA_MODE_WMASK) : mode_ff;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mode_ff <= `SQA_MODE_RESET;
        end else begin
            mode_ff <= nxt_mode;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    chk_ready_pulse: assert property (pready_ff |=> !pready_ff)
        else $error("ready held past one cycle");
    chk_apb_wait: assert property (apbReq.psel && !apbReq.penable |=> !pready_ff ##1 pready_ff)
        else $error("apb answer not at second access edge");
    chk_ready_sel: assert property (pready_ff |-> apbReq.psel && apbReq.penable)
        else $error("ready without access phase");
    chk_reset_quiet: assert property (disable iff (1'b0) reset |-> !dqOe_ff && !pready_ff)
        else $error("outputs active in reset");
    chk_err_unmapped: assert property (pready_ff && apbReq.paddr > 12'h00c |-> pslverr_ff)
        else $error("unmapped access without error");
    chk_err_mapped: assert property (pready_ff && apbReq.paddr <= 12'h00c &&
        apbReq.paddr[1:0] == 2'b00 |-> !pslverr_ff)
        else $error("mapped access flagged");
    chk_unmapped_zero: assert property (pready_ff && !apbReq.pwrite &&
        apbReq.paddr > 12'h00c |-> prdata_ff == 32'h0)
        else $error("unmapped read not zero");
    chk_mode_back: assert property (pready_ff && !apbReq.pwrite &&
        apbReq.paddr == 12'h000 |-> prdata_ff == mode_ff)
        else $error("mode readback differs");
    chk_read_lat: assert property ($rose(dqOe_ff) |-> cl2 ? $past(isRead, 2) : $past(isRead, 3))
        else $error("read data at wrong latency");
endmodule : sqa_device_checker

bind sqa_device sqa_device_checker #(.DATA_W(DATA_W), .ROW_W(ROW_W), .COL_W(COL_W)) u_chk (
    .clk_sys(clk_sys), .reset(reset), .pins(pins), .dqIn(dqIn), .dqOut_ff(dqOut_ff),
    .dqOe_ff(dqOe_ff), .apbReq(apbReq), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff));

// ===== sqa_ctrl_model.sv
// controller side model: drives commands and write data, collects read beats
`timescale 1ns/1ns
module sqa_ctrl_model
    import sqa_pkg::*;
(
    input wire logic clk_sys, // system clock
    output sqa_pins_type pins, // command pins
    output logic [15:0] dqIn, // write data
    input wire logic [15:0] dqOut_ff, // read data
    input wire logic dqOe_ff // read data driven
);
    logic [15:0] beats[$];
    function automatic sqa_pins_type mk(logic k, logic [3:0] c, logic [1:0] b, logic [11:0] a);
        return {k, c, b, a};
    endfunction : mk
    initial begin
        pins = mk(1'b1, 4'h7, 2'b00, 12'h000);
        dqIn = 16'hffff;
    end
    always @(posedge clk_sys) begin
        if (dqOe_ff === 1'b1) begin
            beats.push_back(dqOut_ff);
        end
    end
    task cmd(input logic k, input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
        @(posedge clk_sys);
        pins <= mk(k, c, b, a);
    endtask : cmd
    task wr(input logic [1:0] b, input logic [11:0] a, input logic [15:0] d[4]);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            pins <= (k == 0) ? mk(1'b1, CMD_WRITE, b, a) : mk(1'b1, 4'h7, 2'b00, 12'h000);
            dqIn <= d[k];
        end
        @(posedge clk_sys);
        dqIn <= ~d[3];
    endtask : wr
endmodule : sqa_ctrl_model

// ===== tb.sv
// self-checking bench for the sdram device
`timescale 1ns/1ns
module tb;
    import sqa_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b0;
    sqa_pins_type pins;
    logic [15:0] dqIn;
    logic [15:0] dqOut_ff;
    logic dqOe_ff;
    sqa_apb_req_type apbReq = '0;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    int err_total = 0;
    int checked = 0;
    logic [31:0] rd;
    logic er;
    logic [15:0] d[4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
    sqa_device #(.DATA_W(16), .ROW_W(4), .COL_W(4)) DUT (.clk_sys(clk_sys), .reset(reset),
        .pins(pins), .dqIn(dqIn), .dqOut_ff(dqOut_ff), .dqOe_ff(dqOe_ff), .apbReq(apbReq),
        .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff));
    sqa_ctrl_model ctl (.clk_sys(clk_sys), .pins(pins), .dqIn(dqIn), .dqOut_ff(dqOut_ff),
        .dqOe_ff(dqOe_ff));
    task conclude;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        @(posedge clk_sys);
        apbReq <= '{1'b1, 1'b0, wr, ad, wd};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready_ff !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            conclude();
        end
        rd = prdata_ff;
        er = pslverr_ff;
        apbReq <= '0;
    endtask : apb
    task rd_burst(input logic [1:0] b, input logic [11:0] a);
        ctl.beats.delete();
        ctl.cmd(1'b1, CMD_READ, b, a);
        ctl.cmd(1'b1, 4'h7, 2'b00, 12'h000);
        repeat (10) @(posedge clk_sys);
    endtask : rd_burst
    task t_regs;
        apb(1'b0, 12'h000, 32'h0);
        check("mode reset", rd, 32'h23);
        apb(1'b0, 12'h004, 32'h0);
        check("status reset", rd, 32'h80);
        apb(1'b1, 12'h000, 32'hffff_ffff);
        apb(1'b0, 12'h000, 32'h0);
        check("mode mask", rd, 32'h13f);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped err", {31'h0, er}, 32'h1);
    endtask : t_regs
    task t_burst;
        apb(1'b1, 12'h000, 32'h22);
        ctl.cmd(1'b1, CMD_ACTIVE, 2'b01, 12'h005);
        ctl.wr(2'b01, 12'h000, d);
        rd_burst(2'b01, 12'h002);
        check("seq count", ctl.beats.size(), 4);
        for (int i = 0; i < 4; i++) check("seq beat", ctl.beats[i], d[(2 + i) % 4]);
        apb(1'b1, 12'h000, 32'h3a);
        rd_burst(2'b01, 12'h001);
        for (int i = 0; i < 4; i++) check("ilv beat", ctl.beats[i], d[1 ^ i]);
    endtask : t_burst
    task t_refuse;
        rd_burst(2'b10, 12'h000);
        check("closed read", ctl.beats.size(), 0);
        apb(1'b0, 12'h00c, 32'h0);
        check("misuse set", rd[1], 1'b1);
        apb(1'b1, 12'h00c, 32'h2);
        apb(1'b0, 12'h00c, 32'h0);
        check("misuse clear", rd[1], 1'b0);
    endtask : t_refuse
    task t_stop;
        apb(1'b1, 12'h000, 32'h27);
        ctl.cmd(1'b1, CMD_ACTIVE, 2'b00, 12'h003);
        ctl.beats.delete();
        ctl.cmd(1'b1, CMD_READ, 2'b01, 12'h000);
        ctl.cmd(1'b1, CMD_PRE, 2'b00, 12'h000);
        ctl.cmd(1'b1, CMD_BST, 2'b00, 12'h000);
        ctl.cmd(1'b1, 4'h7, 2'b00, 12'h000);
        repeat (20) @(posedge clk_sys);
        check("stop short", ctl.beats.size() inside {[2:15]}, 1'b1);
        check("stop beat0", ctl.beats[0], d[0]);
        check("stop beat1", ctl.beats[1], d[1]);
        apb(1'b0, 12'h004, 32'h0);
        check("banks open", rd[3:0], 4'b0010);
    endtask : t_stop
    task t_refresh;
        logic [11:0] base;
        // close every row before the refresh
        ctl.cmd(1'b1, CMD_PRE, 2'b00, 12'h400);
        ctl.cmd(1'b1, 4'h7, 2'b00, 12'h000);
        apb(1'b0, 12'h008, 32'h0);
        base = rd[11:0];
        ctl.cmd(1'b1, CMD_REF, 2'b00, 12'h000);
        ctl.cmd(1'b1, 4'h7, 2'b00, 12'h000);
        apb(1'b0, 12'h008, 32'h0);
        check("refresh count", rd[11:0], base + 12'h001);
    endtask : t_refresh
    task t_auto;
        apb(1'b1, 12'h000, 32'h20);
        ctl.cmd(1'b1, CMD_ACTIVE, 2'b11, 12'h001);
        rd_burst(2'b11, 12'h402);
        check("single beat", ctl.beats.size(), 1);
        apb(1'b0, 12'h004, 32'h0);
        check("auto closed", rd[3], 1'b0);
        apb(1'b1, 12'h000, 32'h120);
        ctl.cmd(1'b0, CMD_REF, 2'b00, 12'h000);
        ctl.cmd(1'b0, 4'h7, 2'b00, 12'h000);
        apb(1'b0, 12'h00c, 32'h0);
        check("self refused", rd[0], 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        check("power down", rd[9:7], 3'b010);
        ctl.cmd(1'b1, 4'h7, 2'b00, 12'h000);
        apb(1'b0, 12'h004, 32'h0);
        check("power run", rd[9:7], 3'b001);
        apb(1'b1, 12'h000, 32'h20);
        ctl.cmd(1'b0, CMD_REF, 2'b00, 12'h000);
        ctl.cmd(1'b0, 4'h7, 2'b00, 12'h000);
        apb(1'b0, 12'h004, 32'h0);
        check("self entered", rd[9:7], 3'b100);
        ctl.cmd(1'b1, 4'h7, 2'b00, 12'h000);
        apb(1'b0, 12'h004, 32'h0);
        check("self exit", rd[9:7], 3'b001);
    endtask : t_auto
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        reset <= 1'b1;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs();
        t_burst();
        t_refuse();
        t_stop();
        t_refresh();
        t_auto();
        conclude();
    end
endmodule : tb
